// >>> rtl/bpc_power_ctrl.sv
// power state control and status double-word of the bridge
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.svh"

module bpc_power_ctrl #(
  parameter int INT_RST_CYCLES = `BPC_INT_RST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bpc_pkg::bpc_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic power_event_req,
  output logic power_event_out_n,
  output logic int_reset_out,
  output logic bus_reset_out_n,
  output logic [1:0] power_state
);

  bpc_pkg::bpc_ctl_state_t st_ff;
  bpc_pkg::bpc_ctl_state_t nxt_st;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------

  // only full-on and deep sleep codes are implemented
  function automatic logic ps_legal(input logic [1:0] code);
    ps_legal = (code == `BPC_PS_FULL_ON) || (code == `BPC_PS_DEEP);
  endfunction

  // assemble the read image; unlisted bits stay zero
  function automatic logic [31:0] rd_word(input bpc_pkg::bpc_ctl_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BPC_PS_MSB:`BPC_PS_LSB] = s.pstate;
    w[`BPC_KEEP_BIT] = `BPC_KEEP_VAL;
    w[`BPC_PME_EN_BIT] = s.pme_en;
    w[`BPC_PME_STS_BIT] = s.pme_sts;
    w[`BPC_B2B3_BIT] = `BPC_B2B3_VAL;
    w[`BPC_BPCC_BIT] = `BPC_BPCC_VAL;
    rd_word = w;
  endfunction

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [1:0] wr_ps;
  logic leave_deep;

  // decode the single mapped word
  assign hit = (reg_req.addr == `BPC_PCS_OFFSET);
  assign wr_hit = reg_req.wr && hit;
  assign rd_hit = reg_req.rd && hit;
  assign wr_ps = reg_req.wdata[`BPC_PS_MSB:`BPC_PS_LSB];
  assign leave_deep = wr_hit && (st_ff.pstate == `BPC_PS_DEEP) && (wr_ps == `BPC_PS_FULL_ON);

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.leave = leave_deep;
    if (wr_hit) begin
      // drop unimplemented codes, keep the held state
      if (ps_legal(wr_ps)) begin
        nxt_st.pstate = wr_ps;
      end
      nxt_st.pme_en = reg_req.wdata[`BPC_PME_EN_BIT];
      if (reg_req.wdata[`BPC_PME_STS_BIT]) begin
        nxt_st.pme_sts = 1'b0;
      end
    end
    // a new event wins over a clear in the same cycle
    if (power_event_req) begin
      nxt_st.pme_sts = 1'b1;
    end
    // read data stand only in the cycle after the strobe
    if (rd_hit) begin
      nxt_st.rdata = rd_word(st_ff);
    end
    // event output is not gated by power state
    nxt_st.evt_n = ~(nxt_st.pme_en & nxt_st.pme_sts);
  end

  // ----------------------------------------------------------------------------
  // state register; the internal reset does not touch it
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff.pstate <= `BPC_PS_FULL_ON;
      st_ff.pme_en <= `BPC_PME_EN_RST;
      st_ff.pme_sts <= `BPC_PME_STS_RST;
      st_ff.evt_n <= 1'b1;
      st_ff.leave <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------------
  // internal reset sequencer
  // ----------------------------------------------------------------------------
  bpc_int_reset #(
    .RST_CYCLES(INT_RST_CYCLES)
  ) u_int_reset (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(st_ff.leave),
    .busy(int_reset_out)
  );

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------

  // bus reset follows only the external reset
  assign bus_reset_out_n = ~rst;
  assign reg_rdata = st_ff.rdata;
  assign power_event_out_n = st_ff.evt_n;
  assign power_state = st_ff.pstate;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // all checks run on the core clock and pause in reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic rd_q;
  logic wr_clr_q;
  // delayed strobes for the read and clear checks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_clr_q <= 1'b0;
    end else begin
      rd_q <= rd_hit;
      wr_clr_q <= wr_hit && reg_req.wdata[`BPC_PME_STS_BIT] && !power_event_req;
    end
  end

  // ----------------------------------------------------------------------------
  // power state checks
  // ----------------------------------------------------------------------------

  ps_hold_a: assert property (
    !wr_hit |=> power_state == $past(power_state))
    else $error("power state changed without a write");

  exit_state_a: assert property (
    leave_deep |=> power_state == `BPC_PS_FULL_ON)
    else $error("deep sleep exit did not reach full-on");

  ps_drop_en_a: assert property (
    wr_hit && !ps_legal(wr_ps) |=> st_ff.pme_en == $past(reg_req.wdata[`BPC_PME_EN_BIT]))
    else $error("dropped state write lost the enable bit");

  ps_legal_a: assert property (
    ps_legal(power_state))
    else $error("power state holds an unimplemented code");

  ps_ignore_a: assert property (
    wr_hit && !ps_legal(wr_ps) |=> power_state == $past(power_state))
    else $error("unimplemented power state write was taken");

  ps_take_a: assert property (
    wr_hit && ps_legal(wr_ps) |=> power_state == $past(wr_ps))
    else $error("legal power state write was lost");

  deep_exit_a: assert property (
    leave_deep && !int_reset_out |=> ##1 int_reset_out && bus_reset_out_n)
    else $error("deep sleep exit gave no internal reset");

  no_spurious_a: assert property (
    $rose(int_reset_out) |-> $past(leave_deep, 2))
    else $error("internal reset without deep sleep exit");

  keep_bit_a: assert property (
    rd_hit |=> reg_rdata[`BPC_KEEP_BIT] == 1'b1)
    else $error("preserve bit does not read one");

  // ----------------------------------------------------------------------------
  // enable and event output checks
  // ----------------------------------------------------------------------------

  en_write_a: assert property (
    wr_hit |=> st_ff.pme_en == $past(reg_req.wdata[`BPC_PME_EN_BIT]))
    else $error("enable write not taken");

  en_hold_a: assert property (
    !wr_hit |=> st_ff.pme_en == $past(st_ff.pme_en))
    else $error("enable changed without a write");

  en_keep_a: assert property (
    int_reset_out && !$past(wr_hit) |-> st_ff.pme_en == $past(st_ff.pme_en))
    else $error("enable changed across internal reset");

  evt_on_a: assert property (
    st_ff.pme_en && st_ff.pme_sts |-> !power_event_out_n)
    else $error("enabled pending event not driven");

  evt_off_a: assert property (
    !power_event_out_n |-> st_ff.pme_en && st_ff.pme_sts)
    else $error("event output low without enable and status");

  evt_hold_a: assert property (
    !power_event_out_n && !wr_hit |=> !power_event_out_n)
    else $error("event output released without a write");

  pme_gate_a: assert property (
    !st_ff.pme_en |-> power_event_out_n)
    else $error("power event asserted while disabled");

  pme_fire_a: assert property (
    power_event_req && (wr_hit ? reg_req.wdata[`BPC_PME_EN_BIT] : st_ff.pme_en) |=> !power_event_out_n)
    else $error("enabled power event not asserted in this state");

  // ----------------------------------------------------------------------------
  // read image checks
  // ----------------------------------------------------------------------------

  rd_state_a: assert property (
    rd_hit |=> reg_rdata[`BPC_PS_MSB:`BPC_PS_LSB] == $past(power_state))
    else $error("read power state differs from held state");

  rd_flags_a: assert property (
    rd_hit |=> reg_rdata[`BPC_PME_EN_BIT] == $past(st_ff.pme_en) && reg_rdata[`BPC_PME_STS_BIT] == $past(st_ff.pme_sts))
    else $error("read enable or status differs from held flags");

  miss_read_a: assert property (
    reg_req.rd && !hit |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  miss_write_a: assert property (
    reg_req.wr && !hit |=> power_state == $past(power_state) && st_ff.pme_en == $past(st_ff.pme_en))
    else $error("unmapped write changed the word");

  data_zero_a: assert property (
    rd_q |-> reg_rdata[14:9] == 6'h00 && reg_rdata[31:24] == 8'h00)
    else $error("data fields not zero");

  b2b3_zero_a: assert property (
    rd_q |-> !reg_rdata[`BPC_B2B3_BIT])
    else $error("bus power-down support bit set");

  bpcc_zero_a: assert property (
    rd_q |-> !reg_rdata[`BPC_BPCC_BIT])
    else $error("bus power clock control bit set");

  // ----------------------------------------------------------------------------
  // status flag and read image checks
  // ----------------------------------------------------------------------------

  sts_stays_a: assert property (
    !st_ff.pme_sts && !power_event_req |=> !st_ff.pme_sts)
    else $error("status set without an event");

  sts_rise_a: assert property (
    $rose(st_ff.pme_sts) |-> $past(power_event_req))
    else $error("status rose without an event");

  sts_set_a: assert property (
    power_event_req |=> st_ff.pme_sts)
    else $error("power event status not set");

  sts_clear_a: assert property (
    wr_clr_q |-> !st_ff.pme_sts)
    else $error("write one did not clear status");

  sts_keep_a: assert property (
    int_reset_out && !$past(power_event_req) && !wr_clr_q |-> st_ff.pme_sts == $past(st_ff.pme_sts))
    else $error("status changed across internal reset");

  sts_hold_a: assert property (
    st_ff.pme_sts && !(wr_hit && reg_req.wdata[`BPC_PME_STS_BIT]) |=> st_ff.pme_sts)
    else $error("status dropped without a clear");

  ro_zero_a: assert property (
    rd_q |-> reg_rdata[2] == 1'b0 && reg_rdata[7:4] == 4'h0 && reg_rdata[21:16] == 6'h00)
    else $error("reserved bits not zero");

  rd_once_a: assert property (
    !rd_q |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside their cycle");

  rd_image_a: assert property (
    rd_hit |=> reg_rdata == rd_word($past(st_ff)))
    else $error("read image does not match state");

  // ----------------------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------------------

  deep_exit_c: cover property (leave_deep ##2 int_reset_out);
  ps_drop_c: cover property (wr_hit && !ps_legal(wr_ps));
  deep_event_c: cover property (power_state == `BPC_PS_DEEP && !power_event_out_n);
  set_clear_c: cover property (power_event_req && wr_hit && reg_req.wdata[`BPC_PME_STS_BIT]);
  exit_retry_c: cover property (leave_deep && int_reset_out);

endmodule // bpc_power_ctrl

`default_nettype wire

// >>> rtl/bpc_defs.svh
// constants of the bridge power state control block
`ifndef BPC_DEFS_SVH
`define BPC_DEFS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define BPC_ADDR_W 8
`define BPC_PCS_OFFSET 8'h94

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BPC_PS_MSB 1
`define BPC_PS_LSB 0
`define BPC_KEEP_BIT 3
`define BPC_PME_EN_BIT 8
`define BPC_PME_STS_BIT 15
`define BPC_B2B3_BIT 22
`define BPC_BPCC_BIT 23

// ----------------------------------------------------------------------------
// codes, fixed values and reset values
// ----------------------------------------------------------------------------
`define BPC_PS_FULL_ON 2'h0
`define BPC_PS_DEEP 2'h3
`define BPC_KEEP_VAL 1'h1
`define BPC_B2B3_VAL 1'h0
`define BPC_BPCC_VAL 1'h0
`define BPC_PME_EN_RST 1'h0
`define BPC_PME_STS_RST 1'h0
`define BPC_PME_SUPPORT 5'h19

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BPC_CLK_PERIOD_NS 25
`define BPC_INT_RST_NS 100
`define BPC_INT_RST_CYC ((`BPC_INT_RST_NS + `BPC_CLK_PERIOD_NS - 1) / `BPC_CLK_PERIOD_NS)

`endif

// >>> rtl/bpc_pkg.sv
// types of the bridge power state control block
package bpc_pkg;

  // --------------------------------------------------------------------------
  // register port request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bpc_reg_req_t;

  // --------------------------------------------------------------------------
  // internal reset sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BPC_RST_IDLE = 2'h1,
    BPC_RST_BUSY = 2'h2
  } bpc_rst_state_t;

  typedef struct packed {
    bpc_rst_state_t st;
    logic [7:0] cnt;
  } bpc_rst_ctx_t;

  // --------------------------------------------------------------------------
  // control block state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pstate;
    logic pme_en;
    logic pme_sts;
    logic evt_n;
    logic leave;
    logic [31:0] rdata;
  } bpc_ctl_state_t;

endpackage

// >>> rtl/bpc_int_reset.sv
// internal device reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.svh"

module bpc_int_reset #(
  parameter int RST_CYCLES = `BPC_INT_RST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);

  bpc_pkg::bpc_rst_ctx_t st_ff;
  bpc_pkg::bpc_rst_ctx_t nxt_st;

  // ----------------------------------------------------------------------------
  // sequencer: hold busy for a fixed number of cycles per start seen in idle; a start while busy is ignored
  // ----------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.st)
      bpc_pkg::BPC_RST_IDLE: begin
        if (start) begin
          nxt_st.st = bpc_pkg::BPC_RST_BUSY;
          nxt_st.cnt = 8'(RST_CYCLES - 1);
        end
      end
      bpc_pkg::BPC_RST_BUSY: begin
        if (st_ff.cnt == 8'h00) begin
          nxt_st.st = bpc_pkg::BPC_RST_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      default: begin
        nxt_st.st = bpc_pkg::BPC_RST_IDLE;
        nxt_st.cnt = 8'h00;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{st: bpc_pkg::BPC_RST_IDLE, cnt: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = (st_ff.st == bpc_pkg::BPC_RST_BUSY); // from state flop

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  logic [7:0] busy_len;
  // length of the current busy stretch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_len <= 8'h00;
    end else begin
      busy_len <= busy ? busy_len + 8'h01 : 8'h00;
    end
  end

  rst_length_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busy) |-> $past(busy_len) == 8'(RST_CYCLES - 1))
    else $error("internal reset length wrong");

endmodule // bpc_int_reset

`default_nettype wire

// >>> sim/bpc_power_ctrl_test.sv
// self-checking testbench of the power state control double-word
`timescale 1ns/1ps
`default_nettype none
`include "bpc_defs.svh"

module bpc_power_ctrl_test;
  // ----------------------------------------------------------------------------
  // signals, counters and model state
  // ----------------------------------------------------------------------------
  localparam int IR_N = 2;
  localparam int MAX_CYC = 3000;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  bpc_pkg::bpc_reg_req_t reg_req = '0;
  logic power_event_req = 1'h0;
  logic [31:0] reg_rdata;
  logic power_event_out_n;
  logic int_reset_out;
  logic bus_reset_out_n;
  logic [1:0] power_state;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 6446;
  int cyc_cnt = 0;
  int m_ps = 0;
  int m_en = 0;
  int m_sts = 0;
  int m_ir = 0;
  int m_pend = 0;
  logic [31:0] m_rd = '0;
  logic [31:0] v;
  logic [31:0] d;
  logic [7:0] a;

  bpc_power_ctrl #(
    .INT_RST_CYCLES(IR_N)
  ) u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .power_event_req(power_event_req),
    .power_event_out_n(power_event_out_n),
    .int_reset_out(int_reset_out),
    .bus_reset_out_n(bus_reset_out_n),
    .power_state(power_state)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one bus cycle, driven right after the edge
  task automatic op(input logic [7:0] ad, input logic [31:0] dt, input logic w, input logic r, input logic p);
    @(posedge ref_clk);
    reg_req <= '{addr: ad, wdata: dt, wr: w, rd: r};
    power_event_req <= p;
  endtask

  task automatic wr_pcs(input logic [31:0] dt);
    op(`BPC_PCS_OFFSET, dt, 1'h1, 1'h0, 1'h0);
  endtask

  task automatic rd_pcs();
    op(`BPC_PCS_OFFSET, 32'h0, 1'h0, 1'h1, 1'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) op(8'h00, 32'h0, 1'h0, 1'h0, 1'h0);
  endtask

  // ----------------------------------------------------------------------------
  // reference model, updated at each sampling edge
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] image();
    return {16'h0000, m_sts[0], 6'h00, m_en[0], 4'h0, 1'h1, 1'h0, m_ps[1:0]};
  endfunction

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_ps = 0;
      m_en = 0;
      m_sts = 0;
      m_ir = 0;
      m_pend = 0;
      m_rd = '0;
    end else begin
      m_rd = 32'h0;
      cyc_cnt++;
      if (m_pend == 1) begin
        m_ir = IR_N;
        m_pend = 0;
      end else if (m_ir > 0) begin
        m_ir--;
      end
      if (reg_req.addr == `BPC_PCS_OFFSET && reg_req.rd) m_rd = image();
      if (reg_req.addr == `BPC_PCS_OFFSET && reg_req.wr) begin
        if (reg_req.wdata[1:0] == 2'h0 || reg_req.wdata[1:0] == 2'h3) begin
          if (m_ps == 3 && reg_req.wdata[1:0] == 2'h0 && m_ir == 0) m_pend = 1;
          m_ps = int'(reg_req.wdata[1:0]);
        end
        m_en = int'(reg_req.wdata[8]);
        if (reg_req.wdata[15]) m_sts = 0;
      end
      if (power_event_req) m_sts = 1;
      if (cyc_cnt == MAX_CYC) begin
        n_errors++;
        end_sim();
      end
    end
  end

  // outputs compared with the model where they are settled
  always @(negedge ref_clk) begin
    if (!rst) begin
      chk(reg_rdata, m_rd);
      chk({30'h0, power_state}, 32'(m_ps));
      chk({31'h0, power_event_out_n}, (m_en == 1 && m_sts == 1) ? 32'h0 : 32'h1);
      chk({31'h0, int_reset_out}, (m_ir > 0) ? 32'h1 : 32'h0);
      chk({31'h0, bus_reset_out_n}, 32'h1);
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    #30;
    chk({31'h0, bus_reset_out_n}, 32'h0);
    repeat (9) @(posedge ref_clk);
    rst <= 1'h0;
    rd_pcs();
    wr_pcs(32'hFFFF_FFFF);
    rd_pcs();
    wr_pcs(32'h0000_0001);
    wr_pcs(32'h0000_0002);
    rd_pcs();
    // deep-sleep exit, then an exit again while the internal reset is high
    wr_pcs(32'h0000_0000);
    wr_pcs(32'h0000_0003);
    wr_pcs(32'h0000_0000);
    idle(IR_N + 2);
    // power event with enable off, then on, then set against clear
    op(8'h00, 32'h0, 1'h0, 1'h0, 1'h1);
    rd_pcs();
    wr_pcs(32'h0000_0100);
    op(`BPC_PCS_OFFSET, 32'h0000_8100, 1'h1, 1'h0, 1'h1);
    rd_pcs();
    wr_pcs(32'h0000_8100);
    op(`BPC_PCS_OFFSET, 32'h0000_0000, 1'h1, 1'h0, 1'h1);
    op(`BPC_PCS_OFFSET, 32'h0000_0100, 1'h1, 1'h0, 1'h1);
    // flags kept across the internal reset
    wr_pcs(32'h0000_8103);
    op(8'h00, 32'h0, 1'h0, 1'h0, 1'h1);
    wr_pcs(32'h0000_0100);
    idle(IR_N + 2);
    rd_pcs();
    rd_pcs();
    // unmapped places
    op(8'h90, 32'hFFFF_FFFF, 1'h1, 1'h0, 1'h0);
    op(8'h98, 32'h0, 1'h0, 1'h1, 1'h0);
    rd_pcs();
    // random traffic
    repeat (400) begin
      v = $random(seed);
      d = $random(seed);
      a = (v[3:0] == 4'h0) ? v[11:4] : `BPC_PCS_OFFSET;
      case (v[17:16])
        2'h0, 2'h1: op(a, d, 1'h1, 1'h0, v[20] & v[21]);
        2'h2: op(a, 32'h0, 1'h0, 1'h1, v[20] & v[21]);
        default: op(a, d, 1'h0, 1'h0, v[20] & v[21]);
      endcase
    end
    idle(IR_N + 3);
    end_sim();
  end
endmodule // bpc_power_ctrl_test
`default_nettype wire
